// >>> rtl/otsel_top.sv
// Output terminal function selector: two settings pick the status driving each terminal.
// Assumes all status inputs are synchronous to core_clk and computed elsewhere.
// Contract
// - Collector terminal has own selection, reset to code 0 running positive.
// - Relay terminal has own selection, reset to code 99 fault output.
// - Codes 0-99 positive; 100+N drives inverted form of code N.
// - Relay refuses 92, 93, 192, 193; collector accepts them.
// - Only the listed code set and 9999 are accepted; others are rejected.
// - Code 0 running at frequency at or above start threshold, not during DC braking; 0.01Hz in PM mode.
// - Code 1 asserts while output frequency has reached command.
// - Code 3 asserts while stall prevention is active.
// - Code 4 asserts at detection frequency; separate threshold in reverse.
// - Code 7 asserts at 85% of regenerative brake duty.
// - Code 8 asserts at 85% thermal accumulation; trip at 100%.
// - Code 11 ready after power-up reset, stays while startable or running.
// - Code 12 after current stays above level longer than detect time.
// - Code 13 after output stays below level longer than detect time.
// - Code 14 feedback below lower limit; code 15 above upper limit.
// - Code 16 asserts while loop control commands forward rotation.
// - Code 25 asserts on cooling fan fault.
// - Code 26 asserts at about 85% of heatsink overheat temperature.
// - Code 46 latches at brownout deceleration until released.
// - Code 47 asserts during closed-loop process control.
// - Code 48 when absolute loop deviation exceeds limit.
// - Code 99 asserts on fault, clears on fault reset.
// - Both terminals may select the same code independently.
`timescale 1ns/1ps
`default_nettype none
module otsel_top
   import otsel_pkg::*;
#(
   parameter int FW = 16, // frequency width, 0.01 Hz units
   parameter int IW = 16, // current width
   parameter int TW = 24  // detection time width in cycles
) (
   input  wire logic          core_clk,
   input  wire logic          resetn,
   // Selection settings
   input  wire logic [13:0]   collector_pin_select,
   input  wire logic          collector_sel_wr,
   input  wire logic [13:0]   relay_pin_select,
   input  wire logic          relay_sel_wr,
   // Frequency status
   input  wire logic [FW-1:0] out_freq,
   input  wire logic [FW-1:0] cmd_freq,
   input  wire logic [FW-1:0] start_speed_threshold,
   input  wire logic [FW-1:0] detect_freq_fwd,
   input  wire logic [FW-1:0] detect_freq_rev,
   input  wire logic          reverse_dir,
   input  wire logic          permanent_magnet_control,
   input  wire logic          dc_brake_active,
   // Protection status
   input  wire logic          current_limit_active,
   input  wire logic [7:0]    regen_duty_pct,
   input  wire logic [7:0]    thermal_pct,
   input  wire logic [7:0]    heatsink_pct,
   input  wire logic          fan_fault,
   input  wire logic          fault_event,
   input  wire logic          fault_reset,
   input  wire logic          init_done,
   input  wire logic          start_inhibit,
   // Current detection
   input  wire logic [IW-1:0] out_current,
   input  wire logic [IW-1:0] overcurrent_level,
   input  wire logic [TW-1:0] overcurrent_time,
   input  wire logic [IW-1:0] low_current_level,
   input  wire logic [TW-1:0] low_current_time,
   // Loop control
   input  wire logic          loop_active,
   input  wire logic [IW-1:0] loop_feedback,
   input  wire logic [IW-1:0] loop_fb_lower,
   input  wire logic [IW-1:0] loop_fb_upper,
   input  wire logic          loop_fwd_cmd,
   input  wire logic signed [IW:0] loop_error,
   input  wire logic [IW-1:0] loop_error_limit,
   // Brownout deceleration
   input  wire logic          brownout_decel_start,
   input  wire logic          brownout_release,
   // Other sources selected by the remaining codes
   input  wire logic [10:0]   aux_status,
   // Terminals and status
   output logic               collector_out,
   output logic               relay_out,
   output logic               thermal_trip,
   output logic               collector_sel_err,
   output logic               relay_sel_err
);
   logic [13:0] col_sel_ff, rly_sel_ff;
   logic        col_out_ff, rly_out_ff, trip_ff, col_err_ff, rly_err_ff;
   logic        brownout_ff, fault_ff;
   logic        col_ok, rly_ok, col_inv, rly_inv;
   logic [6:0]  col_base, rly_base;
   logic        oc_hit, lc_hit;

   // Validators for the stored and the incoming codes
   logic        col_new_ok, rly_new_ok;
   otsel_code_check #(.RELAY(1'b0)) u_col_new (
      .code   (collector_pin_select),
      .valid  (col_new_ok),
      .invert (),
      .base   ()
   );
   otsel_code_check #(.RELAY(1'b1)) u_rly_new (
      .code   (relay_pin_select),
      .valid  (rly_new_ok),
      .invert (),
      .base   ()
   );
   otsel_code_check #(.RELAY(1'b0)) u_col_cur (
      .code   (col_sel_ff),
      .valid  (col_ok),
      .invert (col_inv),
      .base   (col_base)
   );
   otsel_code_check #(.RELAY(1'b1)) u_rly_cur (
      .code   (rly_sel_ff),
      .valid  (rly_ok),
      .invert (rly_inv),
      .base   (rly_base)
   );

   // Continuity timers for the two current detectors
   otsel_cont_timer #(.W(TW)) u_oc (
      .core_clk (core_clk),
      .resetn   (resetn),
      .cond     (out_current > overcurrent_level),
      .limit    (overcurrent_time),
      .hit      (oc_hit)
   );
   otsel_cont_timer #(.W(TW)) u_lc (
      .core_clk (core_clk),
      .resetn   (resetn),
      .cond     (out_current < low_current_level),
      .limit    (low_current_time),
      .hit      (lc_hit)
   );

   // Status decode
   wire logic [FW-1:0] run_thr = permanent_magnet_control ? FW'(OTSEL_PM_RUN_HZ) : start_speed_threshold;
   wire logic          st_run  = (out_freq >= run_thr) && !dc_brake_active;
   wire logic          st_upf  = (out_freq >= cmd_freq);
   wire logic [FW-1:0] det_thr = reverse_dir ? detect_freq_rev : detect_freq_fwd;
   wire logic          st_fdt  = (out_freq >= det_thr);
   wire logic          st_rgn  = (regen_duty_pct >= OTSEL_PRE_PCT);
   wire logic          st_eth  = (thermal_pct >= OTSEL_PRE_PCT);
   wire logic          st_rdy  = init_done && !start_inhibit && !fault_ff;
   wire logic          st_fbl  = loop_active && (loop_feedback < loop_fb_lower);
   wire logic          st_fbh  = loop_active && (loop_feedback > loop_fb_upper);
   wire logic          st_fwd  = loop_active && loop_fwd_cmd;
   wire logic          st_hs   = (heatsink_pct >= OTSEL_PRE_PCT);
   wire logic [IW:0]   err_abs = loop_error[IW] ? (IW+1)'(-loop_error) : loop_error;
   wire logic          st_err  = loop_active && (err_abs > {1'b0, loop_error_limit});

   // Shared source selector; each terminal gets its own copy so both may pick the same code
   function automatic logic pick(input logic [6:0] b, input logic [10:0] st_a, input logic [15:0] st_b);
      case (b)
         C_RUN:  pick = st_b[0];
         C_UPF:  pick = st_b[1];
         C_OVL:  pick = st_b[2];
         C_FDT:  pick = st_b[3];
         C_RGN:  pick = st_b[4];
         C_ETH:  pick = st_b[5];
         C_RDY:  pick = st_b[6];
         C_OC:   pick = st_b[7];
         C_LC:   pick = st_b[8];
         C_FBL:  pick = st_b[9];
         C_FBH:  pick = st_b[10];
         C_FWD:  pick = st_b[11];
         C_FAN:  pick = st_b[12];
         C_HS:   pick = st_b[13];
         C_BRN:  pick = st_b[14];
         C_PID:  pick = st_b[15];
         C_ERR:  pick = st_a[10];
         C_RTY:  pick = st_a[0];
         C_SLP:  pick = st_a[1];
         C_PLS:  pick = st_a[2];
         C_LIFE: pick = st_a[3];
         C_F3:   pick = st_a[4];
         C_AVG:  pick = st_a[5];
         C_CUR:  pick = st_a[6];
         C_MNT:  pick = st_a[7];
         C_REM:  pick = st_a[8];
         C_WRN:  pick = st_a[9];
         C_FLT:  pick = st_a[10] & 1'b0;
         default: pick = 1'b0;
      endcase
   endfunction

   wire logic [15:0] st_main = {loop_active,
                                brownout_ff, st_hs, fan_fault,
                                st_fwd, st_fbh, st_fbl, lc_hit, oc_hit,
                                st_rdy, st_eth, st_rgn, st_fdt,
                                current_limit_active,
                                st_upf, st_run};
   wire logic [10:0] st_aux  = {st_err, aux_status[9:0]};
   wire logic col_pick = (col_base == C_FLT) ? fault_ff : pick(col_base, st_aux, st_main);
   wire logic rly_pick = (rly_base == C_FLT) ? fault_ff : pick(rly_base, st_aux, st_main);
   // Invalid stored code or 9999 leaves the terminal off
   wire logic col_nxt  = col_ok && (col_base != 7'h7f) && (col_pick ^ col_inv);
   wire logic rly_nxt  = rly_ok && (rly_base != 7'h7f) && (rly_pick ^ rly_inv);

   // Selection storage; a refused write keeps the old code
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         col_sel_ff <= OTSEL_COL_RST;
         rly_sel_ff <= OTSEL_RLY_RST;
         col_err_ff <= 1'b0;
         rly_err_ff <= 1'b0;
      end else begin
         if (collector_sel_wr) begin
            if (col_new_ok) col_sel_ff <= collector_pin_select;
            col_err_ff <= !col_new_ok;
         end
         if (relay_sel_wr) begin
            if (rly_new_ok) rly_sel_ff <= relay_pin_select;
            rly_err_ff <= !rly_new_ok;
         end
      end
   end

   // Brownout and fault latches: set wins over release so no event is lost; trip follows the level
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         brownout_ff <= 1'b0;
         fault_ff    <= 1'b0;
         trip_ff     <= 1'b0;
      end else begin
         brownout_ff <= brownout_decel_start || (brownout_ff && !brownout_release);
         fault_ff    <= fault_event || (fault_ff && !fault_reset);
         trip_ff     <= (thermal_pct >= OTSEL_TRIP_PCT);
      end
   end

   // Terminal registers, refreshed every cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         col_out_ff <= 1'b0;
         rly_out_ff <= 1'b0;
      end else begin
         col_out_ff <= col_nxt;
         rly_out_ff <= rly_nxt;
      end
   end

   assign collector_out     = col_out_ff;
   assign relay_out         = rly_out_ff;
   assign thermal_trip      = trip_ff;
   assign collector_sel_err = col_err_ff;
   assign relay_sel_err     = rly_err_ff;
endmodule : otsel_top
`default_nettype wire

// >>> common/otsel_pkg.sv
// Package for the output terminal signal selector: selection codes and reset values.
// Assumes a single control clock; all status inputs are already synchronous.
package otsel_pkg;
   // Polarity split: codes at or above this offset drive the inverted status
   localparam logic [7:0] OTSEL_NEG_OFS    = 8'h64; // 100
   localparam logic [7:0] OTSEL_NEG_MAX    = 8'hc7; // 199
   // Code 9999 selects no function
   localparam logic [13:0] OTSEL_NONE_CODE = 14'h270f;
   // Values after reset
   localparam logic [13:0] OTSEL_COL_RST   = 14'h0000; // running status
   localparam logic [13:0] OTSEL_RLY_RST   = 14'h0063; // fault status, 99
   // Base codes used by the status selector
   localparam logic [6:0] C_RUN  = 7'h00;
   localparam logic [6:0] C_UPF  = 7'h01;
   localparam logic [6:0] C_OVL  = 7'h03;
   localparam logic [6:0] C_FDT  = 7'h04;
   localparam logic [6:0] C_RGN  = 7'h07;
   localparam logic [6:0] C_ETH  = 7'h08;
   localparam logic [6:0] C_RDY  = 7'h0b;
   localparam logic [6:0] C_OC   = 7'h0c;
   localparam logic [6:0] C_LC   = 7'h0d;
   localparam logic [6:0] C_FBL  = 7'h0e;
   localparam logic [6:0] C_FBH  = 7'h0f;
   localparam logic [6:0] C_FWD  = 7'h10;
   localparam logic [6:0] C_FAN  = 7'h19;
   localparam logic [6:0] C_HS   = 7'h1a;
   localparam logic [6:0] C_BRN  = 7'h2e;
   localparam logic [6:0] C_PID  = 7'h2f;
   localparam logic [6:0] C_ERR  = 7'h30;
   localparam logic [6:0] C_RTY  = 7'h40;
   localparam logic [6:0] C_SLP  = 7'h46;
   localparam logic [6:0] C_PLS  = 7'h4f;
   localparam logic [6:0] C_LIFE = 7'h5a;
   localparam logic [6:0] C_F3   = 7'h5b;
   localparam logic [6:0] C_AVG  = 7'h5c;
   localparam logic [6:0] C_CUR  = 7'h5d;
   localparam logic [6:0] C_MNT  = 7'h5f;
   localparam logic [6:0] C_REM  = 7'h60;
   localparam logic [6:0] C_WRN  = 7'h62;
   localparam logic [6:0] C_FLT  = 7'h63;
   // Percent thresholds for pre-alarms and trip
   localparam logic [7:0] OTSEL_PRE_PCT  = 8'h55; // 85
   localparam logic [7:0] OTSEL_TRIP_PCT = 8'h64; // 100
   // Frequency in 0.01 Hz units; 0.01 Hz run threshold in permanent-magnet mode
   localparam logic [15:0] OTSEL_PM_RUN_HZ = 16'h0001;
endpackage : otsel_pkg

// >>> rtl/otsel_code_check.sv
// Code validator for one terminal selection setting.
// Assumes the code is a plain binary setting value written by software.
`timescale 1ns/1ps
`default_nettype none
module otsel_code_check
   import otsel_pkg::*;
#(
   parameter bit RELAY = 1'b0
) (
   input  wire logic [13:0] code,
   output logic             valid,
   output logic             invert,
   output logic [6:0]       base
);
   wire logic       is_none = (code == OTSEL_NONE_CODE);
   wire logic       in_rng  = (code <= {6'h00, OTSEL_NEG_MAX});
   wire logic       neg     = in_rng && (code[7:0] >= OTSEL_NEG_OFS);
   wire logic [7:0] b8      = neg ? code[7:0] - OTSEL_NEG_OFS : code[7:0];
   logic            listed;

   // Accepted base codes; relay refuses the pulse-type 92 and 93
   always_comb begin
      case (b8[6:0])
         C_RUN, C_UPF, C_OVL, C_FDT, C_RGN, C_ETH, C_RDY, C_OC, C_LC, C_FBL, C_FBH, C_FWD,
         C_FAN, C_HS, C_BRN, C_PID, C_ERR, C_RTY, C_SLP, C_PLS, C_LIFE, C_F3, C_MNT,
         C_REM, C_WRN, C_FLT: listed = 1'b1;
         C_AVG, C_CUR: listed = !RELAY;
         default: listed = 1'b0;
      endcase
   end

   assign valid  = is_none || (in_rng && !b8[7] && listed);
   assign invert = neg;
   assign base   = is_none ? 7'h7f : b8[6:0];
endmodule : otsel_code_check
`default_nettype wire

// >>> rtl/otsel_cont_timer.sv
// Continuity timer: output rises only after the condition has held longer than the limit.
// Assumes the limit is in control clock cycles and steady while counting.
`timescale 1ns/1ps
`default_nettype none
module otsel_cont_timer
   import otsel_pkg::*;
#(
   parameter int W = 24
) (
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output logic              hit
);
   logic [W-1:0] cnt_ff;
   logic         hit_ff;
   wire logic    over = (cnt_ff > limit);

   // Any break in the condition restarts the count
   always_ff @(posedge core_clk) begin
      if (!resetn || !cond) begin
         cnt_ff <= '0;
         hit_ff <= 1'b0;
      end else begin
         if (!over) cnt_ff <= cnt_ff + 1'b1;
         hit_ff <= over;
      end
   end
   assign hit = hit_ff;
endmodule : otsel_cont_timer
`default_nettype wire

// >>> dv/otsel_load.sv
// Far-side load model: lamps or contactors wired to the two output terminals.
// Assumes terminal levels are registered on core_clk (1 = conducting).
`timescale 1ns/1ps
`default_nettype none
module otsel_load (
   input  wire logic core_clk,
   input  wire logic collector_out,
   input  wire logic relay_out,
   output int        relay_ops,
   output logic      lamp_on
);
   logic relay_q = 1'b0;
   initial relay_ops = 0;
   // Count contact closures; frequent toggling on the relay wears its contacts
   always @(posedge core_clk) begin
      lamp_on <= collector_out;
      relay_q <= relay_out;
      if (relay_out && !relay_q) relay_ops <= relay_ops + 1;
   end
endmodule : otsel_load
`default_nettype wire

// >>> dv/otsel_props.sv
// Timing and selection checks on the terminal selector's ports.
// Assumes a single core_clk domain with synchronous active-low resetn.
`timescale 1ns/1ps
`default_nettype none
module otsel_props (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [13:0] collector_pin_select,
   input  wire logic        collector_sel_wr,
   input  wire logic [13:0] relay_pin_select,
   input  wire logic        relay_sel_wr,
   input  wire logic        current_limit_active,
   input  wire logic [7:0]  thermal_pct,
   input  wire logic        fault_event,
   input  wire logic        collector_out,
   input  wire logic        relay_out,
   input  wire logic        thermal_trip,
   input  wire logic        collector_sel_err,
   input  wire logic        relay_sel_err
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Trip flag follows the thermal level one cycle later
   chk_trip_level: assert property (resetn |=> thermal_trip == ($past(thermal_pct) >= 8'h64))
      else $error("thermal trip does not follow level");
   // Relay refuses the pulse-type codes, collector takes them
   chk_relay_refuse: assert property (relay_sel_wr && relay_pin_select inside
      {14'h005c, 14'h005d, 14'h00c0, 14'h00c1} |=> relay_sel_err) else $error("relay accepted a refused code");
   chk_col_accept: assert property (collector_sel_wr && collector_pin_select inside
      {14'h005c, 14'h005d, 14'h00c0, 14'h00c1} |=> !collector_sel_err)
      else $error("collector refused a legal code");
   chk_bad_code: assert property (collector_sel_wr && collector_pin_select == 14'h0002 |=> collector_sel_err)
      else $error("unlisted code accepted");
   // Error flag only moves on a write
   chk_err_hold: assert property (!relay_sel_wr |=> $stable(relay_sel_err))
      else $error("relay error flag moved without a write");
   // Fault code drives the relay within two cycles of the fault
   chk_fault_relay: assert property (relay_sel_wr && relay_pin_select == 14'h0063 ##1
      !relay_sel_wr && fault_event ##1 !relay_sel_wr |=> relay_out) else $error("fault not shown on relay");
   // Offset codes invert, base codes pass straight through
   chk_inv_col: assert property (collector_sel_wr && collector_pin_select == 14'h0067 ##1
      !collector_sel_wr [*2] |=> collector_out == !$past(current_limit_active))
      else $error("inverted overload wrong");
   chk_pos_rly: assert property (relay_sel_wr && relay_pin_select == 14'h0003 ##1 !relay_sel_wr [*2]
      |=> relay_out == $past(current_limit_active)) else $error("overload on relay wrong");
endmodule : otsel_props
bind otsel_top otsel_props u_props (.*);
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench: random status levels, every code on both terminals, model compare.
// Assumes otsel_top with default widths; detection times tied short.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import otsel_pkg::*;
   logic core_clk = 1'b0, resetn = 1'b0, collector_sel_wr = 1'b0, relay_sel_wr = 1'b0;
   logic [13:0] collector_pin_select = 14'h0000, relay_pin_select = 14'h0000;
   logic [15:0] out_freq = '0, cmd_freq = '0, start_speed_threshold = '0, detect_freq_fwd = '0, detect_freq_rev = '0;
   logic reverse_dir = 0, permanent_magnet_control = 0, dc_brake_active = 0, current_limit_active = 0, fan_fault = 0;
   logic fault_event = 0, fault_reset = 0, init_done = 0, start_inhibit = 0, loop_active = 0, loop_fwd_cmd = 0;
   logic brownout_decel_start = 0, brownout_release = 0;
   logic [7:0] regen_duty_pct = '0, thermal_pct = '0, heatsink_pct = '0;
   logic [15:0] out_current = '0, overcurrent_level = '0, low_current_level = '0, loop_feedback = '0;
   logic [15:0] loop_fb_lower = '0, loop_fb_upper = '0, loop_error_limit = '0;
   logic [23:0] overcurrent_time = 24'h000003, low_current_time = 24'h000003;
   logic signed [16:0] loop_error = '0;
   logic [10:0] aux_status = '0;
   logic collector_out, relay_out, thermal_trip, collector_sel_err, relay_sel_err, lamp_on;
   int relay_ops, fail_count = 0, n_compared = 0, cs = 0, rs = 99, flt = 0, brn = 0, ce = 0, re = 0;
   int vl[$] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 25, 26, 46, 47, 48, 64, 70, 79, 90, 91, 92, 93, 95, 96, 98, 99};
   int aux[$] = '{64, 70, 79, 90, 91, 92, 93, 95, 96, 98};
   int bad[$] = '{2, 5, 49, 200, 9998, 9999, 16383};

   otsel_top dut (.*);
   otsel_load u_load (.core_clk(core_clk), .collector_out(collector_out), .relay_out(relay_out),
                      .relay_ops(relay_ops), .lamp_on(lamp_on));

   // 20 MHz clock
   always #25 core_clk = ~core_clk;

   // Status level of one base code, from the inputs currently applied
   function automatic int st(int b);
      int e;
      e = loop_error;
      case (b)
         0: return !dc_brake_active &&
                   out_freq >= (permanent_magnet_control ? 16'h0001 : start_speed_threshold);
         1: return out_freq >= cmd_freq;
         3: return current_limit_active;
         4: return out_freq >= (reverse_dir ? detect_freq_rev : detect_freq_fwd);
         7: return regen_duty_pct >= 8'h55;
         8: return thermal_pct >= 8'h55;
         11: return init_done && !start_inhibit && flt == 0;
         12: return out_current > overcurrent_level;
         13: return out_current < low_current_level;
         14: return loop_active && loop_feedback < loop_fb_lower;
         15: return loop_active && loop_feedback > loop_fb_upper;
         16: return loop_active && loop_fwd_cmd;
         25: return fan_fault;
         26: return heatsink_pct >= 8'h55;
         46: return brn;
         47: return loop_active;
         48: return loop_active && (e < 0 ? -e : e) > int'(loop_error_limit);
         99: return flt;
         default: foreach (aux[i]) if (aux[i] == b) return aux_status[i];
      endcase
      return 0;
   endfunction : st

   function automatic int ok(int c, int rly);
      if (c == 9999) return 1;
      if (c > 199 || (rly != 0 && (c % 100 == 92 || c % 100 == 93))) return 0;
      foreach (vl[i]) if (vl[i] == c % 100) return 1;
      return 0;
   endfunction : ok

   // Expected terminal level for a stored code; 9999 keeps the terminal off
   function automatic int tx(int s);
      if (s == 9999) return 0;
      return st(s % 100) ^ (s >= 100);
   endfunction : tx

   task automatic cmp(logic got, int exp);
      if (exp >= 0) begin
         n_compared++;
         if (got !== exp[0]) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp[0]);
         end
      end
   endtask : cmp

   task automatic rnd();
      {out_freq[2:0], cmd_freq[2:0], start_speed_threshold[2:0], detect_freq_fwd[2:0], detect_freq_rev[2:0],
       out_current[2:0], overcurrent_level[2:0], low_current_level[2:0], loop_feedback[2:0], loop_fb_lower[2:0],
       reverse_dir, permanent_magnet_control} = $urandom;
      {loop_fb_upper[2:0], loop_error_limit[2:0], dc_brake_active, current_limit_active, fan_fault, init_done,
       start_inhibit, loop_active, loop_fwd_cmd, aux_status, fault_reset, brownout_release,
       regen_duty_pct[3:0]} = 30'($urandom);
      regen_duty_pct[7:4] = 4'h5;
      thermal_pct = 8'h50 + 8'($urandom % 30);
      heatsink_pct = 8'h50 + 8'($urandom % 10);
      loop_error = 17'($urandom % 16) - 17'sh00008;
      fault_event = ($urandom % 4 == 0);
      brownout_decel_start = ($urandom % 4 == 0);
   endtask : rnd

   // One pass: new levels, optional writes on both terminals, settle, compare
   task automatic step(int c, int r);
      @(posedge core_clk);
      #1;
      rnd();
      if (r == 99) fault_event = 1'b1;
      flt = fault_event ? 1 : fault_reset ? 0 : flt;
      brn = brownout_decel_start ? 1 : brownout_release ? 0 : brn;
      if (c >= 0) begin
         collector_pin_select = 14'(c);
         collector_sel_wr = 1'b1;
         ce = !ok(c, 0);
         if (ce == 0) cs = c;
      end
      if (r >= 0) begin
         relay_pin_select = 14'(r);
         relay_sel_wr = 1'b1;
         re = !ok(r, 1);
         if (re == 0) rs = r;
      end
      @(posedge core_clk);
      #1;
      collector_sel_wr = 1'b0;
      relay_sel_wr = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      cmp(collector_sel_err, ce);
      cmp(relay_sel_err, re);
      cmp(collector_out, tx(cs));
      cmp(lamp_on, tx(cs));
      cmp(relay_out, tx(rs));
      cmp(thermal_trip, thermal_pct >= 8'h64);
   endtask : step

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // Main sequence: reset selections, all codes both polarities, refused codes, random codes
   initial begin
      void'($urandom(45516));
      repeat (3) @(posedge core_clk);
      #1 resetn = 1'b1;
      step(-1, -1);
      for (int k = 0; k < 2; k++) foreach (vl[i]) step(vl[i] + 100 * ((i + k) % 2), vl[i] + 100 * k);
      foreach (bad[i]) step(bad[i], bad[i]);
      repeat (40) step($urandom_range(0, 210), $urandom_range(0, 210));
      test_done();
   end

   // Watchdog well beyond the roughly 1040 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
